// file: shared/limit_pkg.sv
// shared constants for the counter limit and display block
package limit_pkg;

  // counter widths and limit count
  localparam int CNT_W        = 32;
  localparam int NUM_LIMITS   = 4;

  // scaling factor range
  localparam logic [16:0] SCALE_MIN = 17'h00001;
  localparam logic [16:0] SCALE_MAX = 17'h1869F; // 99999

  // timing figures
  localparam int CLK_HZ         = 50_000_000;
  localparam int TENTH_S_MS     = 100;
  localparam int TENTH_CYCLES   = CLK_HZ / 1000 * TENTH_S_MS;
  localparam logic [6:0] BLANK_MIN_S = 7'h01;
  localparam logic [6:0] BLANK_MAX_S = 7'h63;   // 99 s
  localparam logic [6:0] PULSE_MAX_TENTHS = 7'h63; // 9.9 s

  // limit modes
  localparam logic [1:0] MODE_STEP   = 2'h0;
  localparam logic [1:0] MODE_RELOAD = 2'h1;
  localparam logic [1:0] MODE_STOP   = 2'h2;
  localparam logic [1:0] MODE_CLEAR  = 2'h3;

  // display colours
  localparam logic [1:0] COL_RED   = 2'h0;
  localparam logic [1:0] COL_GREEN = 2'h1;
  localparam logic [1:0] COL_AMBER = 2'h2;

  // reset values
  localparam logic [2:0] DEC_RST = 3'h0;

endpackage

// file: rtl/counter_limit_outputs.sv
// limit comparison, relay outputs and display settings of a counter
`timescale 1ns/1ps

module counter_limit_outputs
  import limit_pkg::*;
#(
  parameter int LIMITS = 4,              // 2 or 4 relay outputs
  parameter int TENTH  = TENTH_CYCLES    // cycles in 0.1 s
)(
  input  wire logic              clock_i,        // 50 MHz clock
  input  wire logic              reset_n_i,      // async reset, low
  input  wire logic              count_up_i,     // count pulse up
  input  wire logic              count_dn_i,     // count pulse down
  input  wire logic              count_reset_i,  // reset command pulse
  input  wire logic              button_i,       // any operator button
  input  wire logic              programming_colour_mode_i,    // programming mode
  input  wire logic              show_total_i,   // show totalizer
  input  wire logic              scale_multiply_i, // 1 mul, 0 div
  input  wire logic [16:0]       scale_value_i,  // scale factor
  input  wire logic [2:0]        decimals_i,     // fractional digits
  input  wire logic signed [CNT_W-1:0] offset_i, // reload offset
  input  wire logic              brightness_setting_i, // 1 high
  input  wire logic [1:0]        run_colour_i,   // run colour
  input  wire logic [1:0]        programming_colour_i, // programming_colour colour
  input  wire logic [1:0]        total_colour_i, // totalizer colour
  input  wire logic              blank_en_i,     // display-off enable
  input  wire logic [6:0]        blank_secs_i,   // 1..99 s
  input  wire logic [3:0]        lim_en_i,       // limit enables
  input  wire logic [3:0]        lim_src_total_i, // 1 totalizer
  input  wire logic [3:0]        lim_dir_high_i, // 1 high, 0 low
  input  wire logic [3:0]        lim_latch_i,    // 1 latch, 0 wiper
  input  wire logic [7:0]        lim_mode_i,     // 2 bits per limit
  input  wire logic [6:0]        pulse_tenths_i, // wiper 0..99 tenths
  input  wire logic signed [CNT_W-1:0] first_limit_i,  // limit 1
  input  wire logic signed [CNT_W-1:0] second_limit_i, // limit 2
  input  wire logic signed [CNT_W-1:0] third_limit_i,  // limit 3
  input  wire logic signed [CNT_W-1:0] fourth_limit_i, // limit 4
  output logic signed [CNT_W-1:0] main_counter_o, // main count
  output logic signed [CNT_W-1:0] total_o,        // totalizer
  output logic signed [CNT_W-1:0] display_value_o, // scaled count, or totalizer
  output logic [2:0]             display_dp_o,   // decimal digits
  output logic                   display_on_o,   // display lit
  output logic                   right_dp_o,     // right dp lamp
  output logic                   brightness_o,   // 1 high
  output logic [1:0]             colour_o,       // colour shown
  output logic                   halted_o,       // counting stopped
  output logic                   first_output_o, // relay 1
  output logic                   second_output_o, // relay 2
  output logic                   third_output_o, // relay 3
  output logic                   fourth_output_o  // relay 4
);

  ////////////////////////////////////////////////////////////////////
  // helpers

  // signed compare with direction, used per limit
  function automatic logic dir_hit(input logic signed [CNT_W-1:0] v,
                                   input logic signed [CNT_W-1:0] l,
                                   input logic hi);
    dir_hit = hi ? (v >= l) : (v <= l);
  endfunction

  // three-stage synchroniser, edge counted when stage 2 and 3 agree
  function automatic logic rise(input logic [2:0] s,
                                input logic prev);
    rise = (s[1] == s[2]) && s[2] && !prev;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // pin input synchronisers

  logic [2:0] up_s_q, dn_s_q, rst_s_q, btn_s_q;
  logic [3:0] lvl_q, lvl_d;   // debounced levels
  logic       up_ev, dn_ev, rst_ev, btn_ev;

  // stage chain; first stage read only by the second
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      up_s_q  <= 3'h0;
      dn_s_q  <= 3'h0;
      rst_s_q <= 3'h0;
      btn_s_q <= 3'h0;
      lvl_q   <= 4'h0;
    end
    else
    begin
      up_s_q  <= {up_s_q[1:0], count_up_i};
      dn_s_q  <= {dn_s_q[1:0], count_dn_i};
      rst_s_q <= {rst_s_q[1:0], count_reset_i};
      btn_s_q <= {btn_s_q[1:0], button_i};
      lvl_q   <= lvl_d;
    end
  end

  // accepted level follows only when stages 2 and 3 agree
  always_comb
  begin
    lvl_d  = lvl_q;
    up_ev  = rise(up_s_q, lvl_q[0]);
    dn_ev  = rise(dn_s_q, lvl_q[1]);
    rst_ev = rise(rst_s_q, lvl_q[2]);
    btn_ev = rise(btn_s_q, lvl_q[3]);
    if (up_s_q[1] == up_s_q[2])
      lvl_d[0] = up_s_q[2];
    if (dn_s_q[1] == dn_s_q[2])
      lvl_d[1] = dn_s_q[2];
    if (rst_s_q[1] == rst_s_q[2])
      lvl_d[2] = rst_s_q[2];
    if (btn_s_q[1] == btn_s_q[2])
      lvl_d[3] = btn_s_q[2];
  end

  ////////////////////////////////////////////////////////////////////
  // 0.1 s tick divider

  logic [$clog2(TENTH)-1:0] div_q, div_d;
  logic [3:0]               tenths_q, tenths_d;
  logic                     tick;       // 0.1 s enable
  logic                     sec_tick;   // 1 s enable

  always_comb
  begin
    tick     = (div_q == ($clog2(TENTH))'(TENTH - 1));
    div_d    = tick ? '0 : div_q + 1'b1;
    sec_tick = tick && (tenths_q == 4'h9);
    tenths_d = tenths_q;
    if (tick)
      tenths_d = sec_tick ? 4'h0 : tenths_q + 4'h1;
    // a press restarts the seconds phase, else blanking comes early
    if (btn_ev)
      tenths_d = 4'h0;
  end

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      div_q    <= '0;
      tenths_q <= 4'h0;
    end
    else
    begin
      div_q    <= div_d;
      tenths_q <= tenths_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // counters and limit logic

  logic signed [CNT_W-1:0] main_q, main_d, tot_q, tot_d;
  logic                    halt_q, halt_d;
  logic [3:0]              out_q, out_d;
  logic [3:0]              hit_q, hit_d;     // last compare result
  logic [6:0]              wipe_q [4];
  logic [6:0]              wipe_d [4];
  logic signed [CNT_W-1:0] lim   [4];
  logic [3:0]              hit, reach, present, latch_eff;
  logic [1:0]              mode  [4];
  logic                    reload_any;
  logic                    counted;

  assign lim[0] = first_limit_i;
  assign lim[1] = second_limit_i;
  assign lim[2] = third_limit_i;
  assign lim[3] = fourth_limit_i;

  // next counter values and output states
  always_comb
  begin
    main_d  = main_q;
    tot_d   = tot_q;
    halt_d  = halt_q;
    out_d   = out_q;
    counted = !halt_q && (up_ev ^ dn_ev);
    reload_any = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      mode[i] = lim_mode_i[2*i +: 2];
      present[i] = (i < LIMITS) && lim_en_i[i];
      latch_eff[i] = lim_latch_i[i] && (mode[i] != MODE_RELOAD);
      hit[i] = dir_hit(lim_src_total_i[i] ? tot_q : main_q, lim[i],
                       lim_dir_high_i[i]);
      reach[i] = present[i] && hit[i] && !hit_q[i];
      if (present[i] && mode[i] == MODE_RELOAD)
        reload_any = 1'b1;
    end
    hit_d = hit;
    // count step, stopped while halted
    if (counted)
    begin
      main_d = up_ev ? main_q + 1 : main_q - 1;
      tot_d  = up_ev ? tot_q + 1 : tot_q - 1;
    end
    for (int i = 0; i < 4; i++)
    begin
      wipe_d[i] = wipe_q[i];
      if (tick && wipe_q[i] != 7'h00)
        wipe_d[i] = wipe_q[i] - 7'h01;
      if (!present[i])
      begin
        out_d[i]  = 1'b0;
        wipe_d[i] = 7'h00;
      end
      else if (latch_eff[i] && mode[i] == MODE_STEP)
        out_d[i] = hit[i];
      else if (reach[i])
      begin
        // limit i drives output i; wiper on reach
        out_d[i] = 1'b1;
        if (!latch_eff[i])
          wipe_d[i] = (pulse_tenths_i > PULSE_MAX_TENTHS) ?
                      PULSE_MAX_TENTHS : pulse_tenths_i;
        if (mode[i] == MODE_RELOAD)
        begin
          if (lim_src_total_i[i])
            tot_d = offset_i;
          else
            main_d = offset_i;
          hit_d[i] = 1'b0;
        end
        if (mode[i] == MODE_STOP)
          halt_d = 1'b1;
      end
      else if (!latch_eff[i] && wipe_d[i] == 7'h00)
        out_d[i] = 1'b0;
    end
    // clear previous output in ring order
    for (int i = 0; i < 4; i++)
      if (reach[i] && mode[i] == MODE_CLEAR && !reach[(i + 3) % 4])
      begin
        out_d[(i + 3) % 4]  = 1'b0;
        wipe_d[(i + 3) % 4] = 7'h00;
      end
    for (int i = 0; i < 4; i++)
      if (reload_any && latch_eff[i])
        out_d[i] = 1'b0;
    if (rst_ev)
    begin
      main_d = '0;
      tot_d  = offset_i;
      halt_d = 1'b0;
      out_d  = 4'h0;
      for (int i = 0; i < 4; i++)
        wipe_d[i] = 7'h00;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      main_q <= '0;
      tot_q  <= '0;
      halt_q <= 1'b0;
      out_q  <= 4'h0;
      hit_q  <= 4'h0;
      for (int i = 0; i < 4; i++)
        wipe_q[i] <= 7'h00;
    end
    else
    begin
      main_q <= main_d;
      tot_q  <= tot_d;
      halt_q <= halt_d;
      out_q  <= out_d;
      hit_q  <= hit_d;
      for (int i = 0; i < 4; i++)
        wipe_q[i] <= wipe_d[i];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // display settings and blanking

  logic [6:0]              idle_q, idle_d;
  logic                    dark_q, dark_d;
  logic signed [CNT_W-1:0] scaled;
  logic [16:0]             factor;
  logic [1:0]              colour_d;

  // scale clipped into 1..99999; divide keeps the integer part
  always_comb
  begin
    factor = scale_value_i;
    if (factor < SCALE_MIN)
      factor = SCALE_MIN;
    if (factor > SCALE_MAX)
      factor = SCALE_MAX;
    if (scale_multiply_i)
      scaled = CNT_W'(main_q * $signed({1'b0, factor}));
    else
      scaled = CNT_W'(main_q / $signed({1'b0, factor}));
  end

  // blank timer counts whole seconds without button activity
  always_comb
  begin
    idle_d = idle_q;
    dark_d = dark_q;
    if (sec_tick && idle_q != 7'h7F)
      idle_d = idle_q + 7'h01;
    if (blank_en_i && idle_q >= blank_secs_i && blank_secs_i >= BLANK_MIN_S)
      dark_d = 1'b1;
    if (!blank_en_i)
      dark_d = 1'b0;
    if (btn_ev)
    begin
      idle_d = 7'h00;
      dark_d = 1'b0;
    end
    if (programming_colour_mode_i)
      colour_d = programming_colour_i;
    else if (show_total_i)
      colour_d = total_colour_i;
    else
      colour_d = run_colour_i;
  end

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      idle_q          <= 7'h00;
      dark_q          <= 1'b0;
      display_value_o <= '0;
      display_dp_o    <= DEC_RST;
      display_on_o    <= 1'b0;
      right_dp_o      <= 1'b0;
      brightness_o    <= 1'b0;
      colour_o        <= COL_RED;
    end
    else
    begin
      idle_q          <= idle_d;
      dark_q          <= dark_d;
      display_value_o <= show_total_i ? tot_q : scaled;
      display_dp_o    <= decimals_i;
      display_on_o    <= !dark_d;
      right_dp_o      <= dark_d;
      brightness_o    <= brightness_setting_i;
      colour_o        <= colour_d;
    end
  end

  // counter state straight from flip-flops
  assign main_counter_o  = main_q;
  assign total_o         = tot_q;
  assign halted_o        = halt_q;
  assign first_output_o  = out_q[0];
  assign second_output_o = out_q[1];
  assign third_output_o  = out_q[2];
  assign fourth_output_o = out_q[3];

endmodule

// file: verif/limit_checker.sv
// concurrent checks on the limit and display ports
`timescale 1ns/1ps
module limit_checker
  import limit_pkg::*;
(
  input wire logic                    clock_i,         // clock
  input wire logic                    reset_n_i,       // async reset, low
  input wire logic                    count_reset_i,   // reset pin
  input wire logic                    button_i,        // button pin
  input wire logic                    brightness_setting_i, // level
  input wire logic                    blank_en_i,      // blank enable
  input wire logic signed [CNT_W-1:0] offset_i,        // offset
  input wire logic [3:0]              lim_en_i,        // enables
  input wire logic [3:0]              lim_latch_i,     // latch timing
  input wire logic [7:0]              lim_mode_i,      // modes
  input wire logic signed [CNT_W-1:0] main_counter_o,  // main count
  input wire logic signed [CNT_W-1:0] total_o,         // totalizer
  input wire logic                    display_on_o,    // lit
  input wire logic                    right_dp_o,      // right dp
  input wire logic                    brightness_o,    // brightness
  input wire logic                    halted_o,        // halted
  input wire logic                    first_output_o,  // relay 1
  input wire logic                    second_output_o, // relay 2
  input wire logic                    third_output_o   // relay 3
);
  logic [1:0] up_q;
  logic [1:0] up_d;
  logic       ok;
  logic       rl_cfg;
  // settle count: keeps $past away from values taken during reset
  always_comb
  begin
    up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
  end
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      up_q <= 2'h0;
    else
      up_q <= up_d;
  end
  // helper conditions
  assign ok = (up_q == 2'h3);
  assign rl_cfg = lim_en_i[3] && lim_mode_i[7:6] == MODE_RELOAD
                  && lim_en_i[2] && lim_latch_i[2];
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  // pin pulses held for two samples
  sequence s_rst;
    ok && $rose(count_reset_i) ##1 count_reset_i;
  endsequence
  sequence s_btn;
    ok && $rose(button_i) ##1 button_i;
  endsequence
  a_bright_follow: assert property (ok && $stable(brightness_setting_i)
    |-> brightness_o == brightness_setting_i) else $error("brightness lag");
  a_blank_dp: assert property (ok && !display_on_o |-> right_dp_o)
    else $error("right dp dark while blank");
  a_blank_off: assert property (ok && !blank_en_i && !$past(blank_en_i)
    |-> display_on_o) else $error("display dark while disabled");
  a_btn_relight: assert property (s_btn |-> ##[1:5] display_on_o)
    else $error("button did not relight");
  a_reset_load: assert property (s_rst
    |-> ##[1:6] (total_o == offset_i && main_counter_o == 0))
    else $error("reset did not load offset");
  a_halt_freeze: assert property (halted_o && $past(halted_o)
    |-> $stable(main_counter_o)) else $error("counted while halted");
  a_stop_halt: assert property (ok && $rose(third_output_o) &&
    lim_en_i[2] && lim_mode_i[5:4] == MODE_STOP |-> ##[0:1] halted_o)
    else $error("stop limit did not halt");
  a_reload_latch: assert property (ok && rl_cfg && $past(rl_cfg)
    |-> !third_output_o) else $error("latch output on in reload");
  a_ring_clear: assert property (ok && $rose(second_output_o) &&
    lim_en_i[1] && lim_mode_i[3:2] == MODE_CLEAR && !$rose(first_output_o)
    |-> ##[0:1] !first_output_o) else $error("previous output kept");
endmodule

bind counter_limit_outputs limit_checker chk_u (
  .clock_i, .reset_n_i, .count_reset_i, .button_i, .brightness_setting_i,
  .blank_en_i, .offset_i, .lim_en_i, .lim_latch_i, .lim_mode_i,
  .main_counter_o, .total_o, .display_on_o, .right_dp_o, .brightness_o,
  .halted_o, .first_output_o, .second_output_o, .third_output_o);

// file: verif/pin_model.sv
// count pulse and push button pins of the far side
`timescale 1ns/1ps
module pin_model (
  input  wire logic clock_i, // bench clock
  output logic      up_o,    // count up pin
  output logic      dn_o,    // count down pin
  output logic      rst_o,   // reset command pin
  output logic      btn_o    // push button pin
);
  logic [3:0] pin_q = 4'h0;
  // pins idle low between pulses
  assign {btn_o, rst_o, dn_o, up_o} = pin_q;
  // three high, three low: longer than the two the sync stages need
  task automatic pulse(input int k);
    @(posedge clock_i);
    pin_q[k] <= 1'b1;
    repeat (3) @(posedge clock_i);
    pin_q[k] <= 1'b0;
    repeat (3) @(posedge clock_i);
  endtask
endmodule

// file: verif/tb.sv
// self-checking bench for the counter limit block
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) fail("mismatch"); end
module tb
  import limit_pkg::*;
;
  logic clock_i = 1'b0, reset_n_i = 1'b0, brightness_setting_i = 1'b0;
  logic programming_colour_mode_i = 1'b0, show_total_i = 1'b0, scale_multiply_i = 1'b1;
  logic blank_en_i = 1'b0;
  logic [16:0] scale_value_i = 17'h00001;
  logic [2:0]  decimals_i = 3'h0;
  logic [1:0]  run_colour_i = 2'h0, programming_colour_i = 2'h1;
  logic [1:0]  total_colour_i = 2'h2;
  logic [6:0]  blank_secs_i = 7'h01, pulse_tenths_i = 7'h02;
  logic [3:0]  lim_en_i = 4'h0, lim_src_total_i = 4'h0;
  logic [3:0]  lim_dir_high_i = 4'hF, lim_latch_i = 4'h0;
  logic [7:0]  lim_mode_i = 8'h00;
  logic signed [CNT_W-1:0] offset_i = 32'h2, lims [4] = '{default: 32'h0};
  logic signed [CNT_W-1:0] main_counter_o, total_o, display_value_o;
  logic signed [CNT_W-1:0] sc_e [3] = '{32'hA, 32'h1, 32'h2};
  logic [16:0] sc_v [3] = '{17'h00005, 17'h00002, 17'h00000};
  logic        sc_m [3] = '{1'b1, 1'b0, 1'b0};
  logic [2:0]  display_dp_o;
  logic [1:0]  colour_o;
  logic display_on_o, right_dp_o, brightness_o, halted_o, first_output_o;
  logic second_output_o, third_output_o, fourth_output_o;
  logic [3:0]  outs_q = 4'h0;
  wire logic count_up_i, count_dn_i, count_reset_i, button_i;
  wire logic signed [CNT_W-1:0] first_limit_i = lims[0];
  wire logic signed [CNT_W-1:0] second_limit_i = lims[1];
  wire logic signed [CNT_W-1:0] third_limit_i = lims[2];
  wire logic signed [CNT_W-1:0] fourth_limit_i = lims[3];
  wire logic [3:0] outs = {fourth_output_o, third_output_o,
                           second_output_o, first_output_o};
  wire logic [1:0] col_x = programming_colour_mode_i ? programming_colour_i :
                           show_total_i ? total_colour_i : run_colour_i;
  int seed = 34, err_total = 0, check_count = 0, note_q[$];

  counter_limit_outputs #(.LIMITS(4), .TENTH(10)) dut_u (
    .clock_i, .reset_n_i, .count_up_i, .count_dn_i, .count_reset_i,
    .button_i, .programming_colour_mode_i, .show_total_i, .scale_multiply_i,
    .scale_value_i, .decimals_i, .offset_i, .brightness_setting_i,
    .run_colour_i, .programming_colour_i, .total_colour_i, .blank_en_i,
    .blank_secs_i, .lim_en_i, .lim_src_total_i, .lim_dir_high_i,
    .lim_latch_i, .lim_mode_i, .pulse_tenths_i, .first_limit_i,
    .second_limit_i, .third_limit_i, .fourth_limit_i, .main_counter_o,
    .total_o, .display_value_o, .display_dp_o, .display_on_o, .right_dp_o,
    .brightness_o, .colour_o, .halted_o, .first_output_o,
    .second_output_o, .third_output_o, .fourth_output_o);
  pin_model pm_u (.clock_i, .up_o(count_up_i), .dn_o(count_dn_i),
                  .rst_o(count_reset_i), .btn_o(button_i));

  // 50 MHz clock
  always #10 clock_i = ~clock_i;

  task automatic fail(input string m);
    err_total++;
    $display("Error at %0t: %s", $time, m);
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  function automatic logic [2:0] rnd(input int n);
    return 3'($unsigned($random(seed)) % n);
  endfunction
  task automatic cfg(input int k, input logic l, input logic [1:0] m,
                     input logic signed [CNT_W-1:0] v);
    @(posedge clock_i);
    lim_en_i[k] <= 1'b1;
    lim_latch_i[k] <= l;
    lim_mode_i[2*k+:2] <= m;
    lims[k] <= v;
  endtask
  // pulses on pin k, then room for sync and the output register
  task automatic cnt(input int k, input int n);
    repeat (n) pm_u.pulse(k);
    repeat (2) @(negedge clock_i);
  endtask

  // relay rises are matched in order against the driver's notes
  always @(negedge clock_i)
  begin
    outs_q <= outs;
    if (reset_n_i && (outs & ~outs_q) != 4'h0)
    begin
      if (note_q.size() == 0)
        fail("unexpected relay");
      else
        `CHK(outs & ~outs_q, 4'(4'h1 << note_q.pop_front()))
    end
  end

  // main sequence
  initial
  begin
    int n;
    repeat (5) @(posedge clock_i);
    reset_n_i <= 1'b1;
    repeat (2) @(negedge clock_i);
    `CHK(display_on_o, 1'b1)
    cfg(0, 1'b1, MODE_STEP, 32'h3);
    note_q.push_back(0);
    cnt(0, 3);
    `CHK(first_output_o, 1'b1)
    cnt(1, 1);
    `CHK(first_output_o, 1'b0)
    done("latch");
    cfg(0, 1'b0, MODE_STEP, 32'h3);
    cfg(1, 1'b0, MODE_CLEAR, 32'h4);
    note_q.push_back(0);
    note_q.push_back(1);
    cnt(0, 2);
    `CHK(second_output_o, 1'b1)
    `CHK(first_output_o, 1'b0)
    repeat (25) @(negedge clock_i);
    `CHK(second_output_o, 1'b0)
    done("clear");
    @(posedge clock_i);
    lim_en_i <= 4'h0;
    cfg(2, 1'b1, MODE_STOP, 32'h6);
    note_q.push_back(2);
    cnt(0, 3);
    `CHK(halted_o, 1'b1)
    `CHK(main_counter_o, 32'h6)
    cnt(2, 1);
    `CHK(halted_o, 1'b0)
    `CHK(total_o, offset_i)
    `CHK(main_counter_o, 32'h0)
    done("stop");
    // reload asked as latch, with a latch held off
    @(posedge clock_i);
    lim_en_i <= 4'h0;
    cfg(3, 1'b1, MODE_RELOAD, 32'h3);
    cfg(2, 1'b1, MODE_STEP, 32'h1);
    note_q.push_back(3);
    cnt(0, 3);
    `CHK(main_counter_o, offset_i)
    `CHK(third_output_o, 1'b0)
    // wiper must end although latch timing was asked for
    repeat (25) @(negedge clock_i);
    `CHK(fourth_output_o, 1'b0)
    done("reload");
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clock_i);
      lim_en_i <= 4'h0;
      brightness_setting_i <= 1'(rnd(2));
      decimals_i <= rnd(5);
      programming_colour_mode_i <= 1'(rnd(2));
      show_total_i <= 1'(rnd(2));
      run_colour_i <= 2'(rnd(3));
      programming_colour_i <= 2'(rnd(3));
      total_colour_i <= 2'(rnd(3));
      repeat (2) @(negedge clock_i);
      `CHK(brightness_o, brightness_setting_i)
      `CHK(display_dp_o, decimals_i)
      `CHK(colour_o, col_x)
    end
    done("display");
    // scaling table on main count 2, zero clipped to one
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clock_i);
      show_total_i <= 1'b0;
      scale_multiply_i <= sc_m[i];
      scale_value_i <= sc_v[i];
      repeat (3) @(negedge clock_i);
      `CHK(display_value_o, sc_e[i])
    end
    done("scale");
    // random offset, totalizer source, low direction
    @(posedge clock_i);
    offset_i <= 32'h10 + 32'(rnd(8));
    lim_src_total_i <= 4'h1;
    lim_dir_high_i <= 4'hE;
    cnt(2, 1);
    `CHK(total_o, offset_i)
    // main count is below the limit, so a main-sourced compare would fire
    cfg(0, 1'b1, MODE_STEP, offset_i - 32'h1);
    repeat (2) @(negedge clock_i);
    `CHK(first_output_o, 1'b0)
    note_q.push_back(0);
    cnt(1, 1);
    `CHK(first_output_o, 1'b1)
    cnt(0, 1);
    `CHK(first_output_o, 1'b0)
    done("source");
    // idle blanking restarted by a button
    @(posedge clock_i);
    blank_en_i <= 1'b1;
    cnt(3, 1);
    for (n = 0; n < 300 && display_on_o === 1'b1; n++)
      @(negedge clock_i);
    `CHK(n > 75 && n < 105, 1'b1)
    `CHK(right_dp_o, 1'b1)
    cnt(3, 1);
    `CHK(display_on_o, 1'b1)
    done("blank");
    if (note_q.size() != 0)
      fail("relay missing");
    stop_test();
  end
endmodule
